/* File: verilog/dualrt_timer.sv */
`timescale 1ns/1ns
module dualrt_timer
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       low_speed_osc,
  input  wire logic       high_speed_osc,
  input  wire logic       nr_clk_tick,
  input  wire logic       event_input_pin,
  input  wire logic       count_source_sel,
  input  wire logic       event_edge_sel,
  input  wire logic       glitch_filter_en,
  input  wire logic       ch0_run,
  input  wire logic       ch1_run,
  input  wire logic       ch0_reload_trigger,
  input  wire logic       ch1_reload_trigger,
  input  wire logic [7:0] ch0_reload_value,
  input  wire logic [7:0] ch1_reload_value,
  input  wire logic       ch0_osc_select,
  input  wire logic       ch1_osc_select,
  input  wire logic       ch0_div_lo,
  input  wire logic       ch0_div_hi,
  input  wire logic [1:0] ch1_div_sel,
  input  wire logic       ch0_lo_read,
  input  wire logic       ch0_hi_read,
  input  wire logic       ch1_lo_read,
  input  wire logic       ch1_hi_read,
  input  wire logic       ch0_irq_mask,
  input  wire logic       ch1_irq_mask,
  input  wire logic       ch0_irq_clear,
  input  wire logic       ch1_irq_clear,
  input  wire logic       toggle_pulse_out_chan_sel,
  input  wire logic       toggle_pulse_out_enable,
  output logic      [7:0] ch0_count_readout,
  output logic      [7:0] ch1_count_readout,
  output logic            ch0_irq_flag,
  output logic            ch1_irq_flag,
  output logic            irq_req,
  output logic            toggle_pulse_out,
  output logic            pulse_output_pin,
  output logic            serial_clk_out
);
  // ************************************************************
  // input synchronisers for asynchronous pins
  // ************************************************************
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync_d;
  logic [3:0] prev_q;
  logic       osc_lo_tick;
  logic       osc_hi_tick;
  logic       nr_fall;

  assign sync_d = {event_input_pin, nr_clk_tick, high_speed_osc, low_speed_osc};

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_q <= {4{dualrt_pkg::BIT_RST}};
      sync2_q <= {4{dualrt_pkg::BIT_RST}};
      prev_q  <= {4{dualrt_pkg::BIT_RST}};
    end
    else
    begin
      sync1_q <= sync_d;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // oscillators are sampled as slow clocks; rising edge is one source tick
  assign osc_lo_tick = sync2_q[0] && !prev_q[0];
  assign osc_hi_tick = sync2_q[1] && !prev_q[1];
  assign nr_fall     = !sync2_q[2] && prev_q[2];

  // ************************************************************
  // noise rejector and edge select for channel 0 event input
  // ************************************************************
  logic       filt_q;
  logic       filt_d;
  logic [1:0] nr_cnt_q;
  logic [1:0] nr_cnt_d;
  logic       ev_level;
  logic       ev_prev_lvl_q;
  logic       ev_edge;

  always_comb
  begin
    filt_d   = filt_q;
    nr_cnt_d = nr_cnt_q;
    if (sync2_q[3] == filt_q)
      nr_cnt_d = dualrt_pkg::NR_RST;
    else if (nr_fall)
    begin
      if (nr_cnt_q == 2'(dualrt_pkg::NR_EDGES - 1))
      begin
        filt_d   = sync2_q[3];
        nr_cnt_d = dualrt_pkg::NR_RST;
      end
      else
        nr_cnt_d = nr_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      filt_q        <= dualrt_pkg::BIT_RST;
      nr_cnt_q      <= dualrt_pkg::NR_RST;
      ev_prev_lvl_q <= dualrt_pkg::BIT_RST;
    end
    else
    begin
      filt_q        <= filt_d;
      nr_cnt_q      <= nr_cnt_d;
      ev_prev_lvl_q <= ev_level;
    end
  end

  assign ev_level = glitch_filter_en ? filt_q : prev_q[3];
  assign ev_edge  = event_edge_sel ? (ev_level && !ev_prev_lvl_q)
                                   : (!ev_level && ev_prev_lvl_q);

  // ************************************************************
  // per-channel prescaler, down counter and readout latch
  // ************************************************************
  logic [1:0] run;
  logic [1:0] trig;
  logic [1:0] osc_sel;
  logic [1:0] div_sel [2];
  logic [7:0] rld [2];
  logic [1:0] lo_rd;
  logic [1:0] hi_rd;
  logic [1:0] msk;
  logic [1:0] iclr;
  logic [1:0] ps_tick;
  logic [1:0] cnt_clk;
  logic [1:0] uflow;
  logic [7:0] cnt_q [2];
  logic [7:0] cnt_d [2];
  logic [3:0] hold_q [2];
  logic [3:0] hold_d [2];
  logic [7:0] rd_q [2];
  logic [7:0] rd_d [2];
  logic [1:0] frz_q;
  logic [1:0] frz_d;
  logic [1:0] iflag_q;
  logic [1:0] iflag_d;

  assign run        = {ch1_run, ch0_run};
  assign trig       = {ch1_reload_trigger, ch0_reload_trigger};
  assign osc_sel    = {ch1_osc_select, ch0_osc_select};
  assign div_sel[0] = {ch0_div_hi, ch0_div_lo};
  assign div_sel[1] = ch1_div_sel;
  assign rld[0]     = ch0_reload_value;
  assign rld[1]     = ch1_reload_value;
  assign lo_rd      = {ch1_lo_read, ch0_lo_read};
  assign hi_rd      = {ch1_hi_read, ch0_hi_read};
  assign msk        = {ch1_irq_mask, ch0_irq_mask};
  assign iclr       = {ch1_irq_clear, ch0_irq_clear};

  // channel 1 never sees the event input
  assign cnt_clk[0] = count_source_sel ? (ch0_run && ev_edge) : ps_tick[0];
  assign cnt_clk[1] = ps_tick[1];

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ch
      dualrt_tick_if tick_bus ();

      assign tick_bus.osc_lo_tick = osc_lo_tick;
      assign tick_bus.osc_hi_tick = osc_hi_tick;
      assign tick_bus.osc_sel     = osc_sel[g];
      assign tick_bus.div_sel     = div_sel[g];
      assign tick_bus.run         = run[g];
      assign tick_bus.clear       = trig[g];
      assign ps_tick[g]           = tick_bus.tick;

      dualrt_prescaler u_presc
      (
        .clk    (clk),
        .arst_n (arst_n),
        .bus    (tick_bus.presc)
      );

      assign uflow[g] = cnt_clk[g] && !trig[g] && (cnt_q[g] == dualrt_pkg::CNT_RST);

      always_comb
      begin
        cnt_d[g]  = cnt_q[g];
        hold_d[g] = hold_q[g];
        frz_d[g]  = frz_q[g];
        if (trig[g] || uflow[g])
          cnt_d[g] = rld[g];
        else if (cnt_clk[g])
          cnt_d[g] = cnt_q[g] - 8'h01;
        if (lo_rd[g])
        begin
          frz_d[g]  = 1'b1;
          hold_d[g] = cnt_q[g][7:4];
        end
        else if (hi_rd[g])
          frz_d[g] = 1'b0;
        // set wins over a clear in the same cycle
        iflag_d[g] = uflow[g] || (iflag_q[g] && !iclr[g]);
        rd_d[g]    = {frz_d[g] ? hold_d[g] : cnt_d[g][7:4], cnt_d[g][3:0]};
      end

      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          cnt_q[g]   <= dualrt_pkg::CNT_RST;
          hold_q[g]  <= dualrt_pkg::NIB_RST;
          frz_q[g]   <= dualrt_pkg::BIT_RST;
          iflag_q[g] <= dualrt_pkg::BIT_RST;
          rd_q[g]    <= dualrt_pkg::CNT_RST;
        end
        else
        begin
          cnt_q[g]   <= cnt_d[g];
          hold_q[g]  <= hold_d[g];
          frz_q[g]   <= frz_d[g];
          iflag_q[g] <= iflag_d[g];
          rd_q[g]    <= rd_d[g];
        end
      end
    end
  endgenerate

  // readout is registered so the high nibble captured at the low read is stable
  assign ch0_count_readout = rd_q[0];
  assign ch1_count_readout = rd_q[1];
  assign ch0_irq_flag      = iflag_q[0];
  assign ch1_irq_flag      = iflag_q[1];
  assign irq_req           = |(iflag_q & msk);

  // ************************************************************
  // toggle output and serial clock
  // ************************************************************
  logic tog_q;
  logic tog_d;
  logic ser_q;
  logic ser_d;

  always_comb
  begin
    tog_d = tog_q ^ uflow[toggle_pulse_out_chan_sel];
    ser_d = ser_q ^ uflow[1];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tog_q <= dualrt_pkg::BIT_RST;
      ser_q <= dualrt_pkg::BIT_RST;
    end
    else
    begin
      tog_q <= tog_d;
      ser_q <= ser_d;
    end
  end

  assign toggle_pulse_out = tog_q;
  // pin idles high when output is off
  assign pulse_output_pin = toggle_pulse_out_enable ? tog_q : 1'b1;
  assign serial_clk_out   = ser_q;
endmodule : dualrt_timer

/* File: verilog/dualrt_pkg.sv */
package dualrt_pkg;
  // ************************************************************
  // widths and prescaler codes
  // ************************************************************
  localparam int unsigned CNT_W     = 8;
  localparam int unsigned PS_W      = 8;
  localparam logic [1:0]  DIV_1     = 2'h0;
  localparam logic [1:0]  DIV_4     = 2'h1;
  localparam logic [1:0]  DIV_32    = 2'h2;
  localparam logic [1:0]  DIV_256   = 2'h3;
  localparam logic [7:0]  PS_MASK_1   = 8'h00;
  localparam logic [7:0]  PS_MASK_4   = 8'h03;
  localparam logic [7:0]  PS_MASK_32  = 8'h1F;
  localparam logic [7:0]  PS_MASK_256 = 8'hFF;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0]  CNT_RST   = 8'h00;
  localparam logic [7:0]  PS_RST    = 8'h00;
  localparam logic [3:0]  NIB_RST   = 4'h0;
  localparam logic [1:0]  NR_RST    = 2'h0;
  localparam logic        BIT_RST   = 1'b0;
  // ************************************************************
  // noise rejector: accept at second falling edge of divided clock
  // ************************************************************
  localparam int unsigned NR_EDGES  = 2;
endpackage : dualrt_pkg

/* File: verilog/dualrt_tick_if.sv */
`timescale 1ns/1ns
interface dualrt_tick_if;
  logic       osc_lo_tick;
  logic       osc_hi_tick;
  logic       osc_sel;
  logic [1:0] div_sel;
  logic       run;
  logic       clear;
  logic       tick;
  modport ctrl
  (
    output osc_lo_tick,
    output osc_hi_tick,
    output osc_sel,
    output div_sel,
    output run,
    output clear,
    input  tick
  );
  modport presc
  (
    input  osc_lo_tick,
    input  osc_hi_tick,
    input  osc_sel,
    input  div_sel,
    input  run,
    input  clear,
    output tick
  );
endinterface : dualrt_tick_if

/* File: verilog/dualrt_prescaler.sv */
`timescale 1ns/1ns
module dualrt_prescaler
(
  input  wire logic  clk,
  input  wire logic  arst_n,
  dualrt_tick_if.presc bus
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       src;
  logic [7:0] mask;

  always_comb
  begin
    src = bus.osc_sel ? bus.osc_hi_tick : bus.osc_lo_tick;
    case (bus.div_sel)
      dualrt_pkg::DIV_1:   mask = dualrt_pkg::PS_MASK_1;
      dualrt_pkg::DIV_4:   mask = dualrt_pkg::PS_MASK_4;
      dualrt_pkg::DIV_32:  mask = dualrt_pkg::PS_MASK_32;
      dualrt_pkg::DIV_256: mask = dualrt_pkg::PS_MASK_256;
      default:             mask = dualrt_pkg::PS_MASK_1;
    endcase
    cnt_d = cnt_q;
    if (bus.clear || !bus.run)
      cnt_d = dualrt_pkg::PS_RST;
    else if (src)
      cnt_d = (cnt_q & mask) == mask ? dualrt_pkg::PS_RST : cnt_q + 8'h01;
    bus.tick = bus.run && src && ((cnt_q & mask) == mask);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= dualrt_pkg::PS_RST;
    else
      cnt_q <= cnt_d;
  end
endmodule : dualrt_prescaler

/* File: sim/dualrt_timer_props.sv */
`timescale 1ns/1ns
module dualrt_timer_props
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       ch1_run,
  input wire logic       ch1_reload_trigger,
  input wire logic [7:0] ch1_reload_value,
  input wire logic       ch1_lo_read,
  input wire logic       ch1_hi_read,
  input wire logic       ch0_irq_mask,
  input wire logic       ch1_irq_mask,
  input wire logic       ch0_irq_clear,
  input wire logic       toggle_pulse_out_chan_sel,
  input wire logic       toggle_pulse_out_enable,
  input wire logic [7:0] ch1_count_readout,
  input wire logic       ch0_irq_flag,
  input wire logic       ch1_irq_flag,
  input wire logic       irq_req,
  input wire logic       toggle_pulse_out,
  input wire logic       pulse_output_pin,
  input wire logic       serial_clk_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ****************************************
  // counting, readout and underflow effects
  // ****************************************
  chk_reload_load: assert property (
    ch1_reload_trigger && !ch1_run |-> ##[1:2] ch1_count_readout == ch1_reload_value)
    else $error("reload value not loaded");
  chk_stop_hold: assert property (
    (!ch1_run && !ch1_reload_trigger) [*3] |=> $stable(ch1_count_readout[3:0]))
    else $error("stopped counter moved");
  chk_hi_frozen: assert property (
    ch1_lo_read ##1 !(ch1_lo_read || ch1_hi_read) |=> $stable(ch1_count_readout[7:4]))
    else $error("high nibble not held");
  chk_reload_wrap: assert property (
    $changed(serial_clk_out) |-> ##[0:2] ch1_count_readout == ch1_reload_value)
    else $error("no reload after underflow");
  chk_ser_flag: assert property (
    $changed(serial_clk_out) |-> ch1_irq_flag)
    else $error("serial clock without flag");
  chk_ser_run: assert property (
    $changed(serial_clk_out) |-> $past(ch1_run))
    else $error("serial clock while stopped");
  chk_irq_gate: assert property (
    irq_req == ((ch0_irq_flag && ch0_irq_mask) || (ch1_irq_flag && ch1_irq_mask)))
    else $error("request not flag and mask");
  chk_flag_sticky: assert property (
    ch0_irq_flag && !ch0_irq_clear |=> ch0_irq_flag)
    else $error("flag dropped without clear");
  chk_toggle_pulse_out_follow: assert property (
    toggle_pulse_out_chan_sel && $stable(toggle_pulse_out_chan_sel)
      |-> $changed(toggle_pulse_out) == $changed(serial_clk_out))
    else $error("toggle output not following");
  chk_pin_mux: assert property (
    pulse_output_pin == (toggle_pulse_out_enable ? toggle_pulse_out : 1'b1))
    else $error("output pin wrong");
  cover property ($changed(serial_clk_out));
  cover property (ch1_lo_read ##2 ch1_hi_read);
  cover property ($rose(ch0_irq_flag));
  cover property (irq_req);
endmodule : dualrt_timer_props
bind dualrt_timer dualrt_timer_props dualrt_timer_props_inst (.clk, .arst_n, .ch1_run,
  .ch1_reload_trigger, .ch1_reload_value, .ch1_lo_read, .ch1_hi_read, .ch0_irq_mask,
  .ch1_irq_mask, .ch0_irq_clear, .toggle_pulse_out_chan_sel, .toggle_pulse_out_enable, .ch1_count_readout,
  .ch0_irq_flag, .ch1_irq_flag, .irq_req, .toggle_pulse_out, .pulse_output_pin,
  .serial_clk_out);

/* File: sim/dualrt_event_src.sv */
`timescale 1ns/1ns
module dualrt_event_src
(
  output logic pin_level
);
  // ****************************************
  // external event source, idles high
  // ****************************************
  initial pin_level = 1'b1;
  // a level stands for the whole hold; short holds are deliberate glitches
  task set_level(input logic v, input int hold_ns);
    pin_level = v;
    #hold_ns;
  endtask : set_level
endmodule : dualrt_event_src

/* File: sim/dual_reload_down_timer_tb_top.sv */
`timescale 1ns/1ns
module dual_reload_down_timer_tb_top;
  typedef struct packed {logic ch; logic osc; logic [1:0] dv; logic [15:0] ex;} dualrt_row_t;
  typedef struct packed {logic e; logic l; logic [7:0] ex;} dualrt_ev_t;
  logic        clk, arst_n, low_speed_osc, high_speed_osc, nr_clk_tick, event_input_pin;
  logic        count_source_sel, event_edge_sel, glitch_filter_en, ch0_run, ch1_run;
  logic        ch0_reload_trigger, ch1_reload_trigger, ch0_osc_select, ch1_osc_select;
  logic        ch0_div_lo, ch0_div_hi, ch0_lo_read, ch0_hi_read, ch1_lo_read, ch1_hi_read;
  logic        ch0_irq_mask, ch1_irq_mask, ch0_irq_clear, ch1_irq_clear, toggle_pulse_out_chan_sel;
  logic        toggle_pulse_out_enable, ch0_irq_flag, ch1_irq_flag, irq_req, toggle_pulse_out;
  logic        pulse_output_pin, serial_clk_out;
  logic [1:0]  ch1_div_sel;
  logic [7:0]  ch0_reload_value, ch1_reload_value, ch0_count_readout, ch1_count_readout;
  int          num_errors, samples_checked, ecnt, e0;
  dualrt_row_t rows [4] = '{'{1'b0, 1'b0, 2'h0, 16'h0003}, '{1'b1, 1'b1, 2'h1, 16'h000C},
                            '{1'b0, 1'b1, 2'h2, 16'h0060}, '{1'b1, 1'b0, 2'h3, 16'h0300}};
  dualrt_ev_t  evs [6] = '{'{1'b0, 1'b0, 8'h01}, '{1'b0, 1'b1, 8'h01}, '{1'b1, 1'b0, 8'h01},
                           '{1'b1, 1'b1, 8'h00}, '{1'b1, 1'b0, 8'h00}, '{1'b1, 1'b1, 8'h02}};
  dualrt_timer dualrt_timer_inst (.clk, .arst_n, .low_speed_osc, .high_speed_osc,
    .nr_clk_tick, .event_input_pin, .count_source_sel, .event_edge_sel, .glitch_filter_en,
    .ch0_run, .ch1_run, .ch0_reload_trigger, .ch1_reload_trigger, .ch0_reload_value,
    .ch1_reload_value, .ch0_osc_select, .ch1_osc_select, .ch0_div_lo, .ch0_div_hi,
    .ch1_div_sel, .ch0_lo_read, .ch0_hi_read, .ch1_lo_read, .ch1_hi_read, .ch0_irq_mask,
    .ch1_irq_mask, .ch0_irq_clear, .ch1_irq_clear, .toggle_pulse_out_chan_sel, .toggle_pulse_out_enable,
    .ch0_count_readout, .ch1_count_readout, .ch0_irq_flag, .ch1_irq_flag, .irq_req,
    .toggle_pulse_out, .pulse_output_pin, .serial_clk_out);
  dualrt_event_src dualrt_event_src_inst (.pin_level(event_input_pin));
  // ****************************************
  // clocks and source edge counting
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // oscillators unrelated to clk so sync latency is exercised
  always #33 low_speed_osc = ~low_speed_osc;
  always #13 high_speed_osc = ~high_speed_osc;
  always #41 nr_clk_tick = ~nr_clk_tick;
  always @(posedge low_speed_osc) if (!ch1_osc_select) ecnt++;
  always @(posedge high_speed_osc) if (ch1_osc_select) ecnt++;
  // ****************************************
  // helpers
  // ****************************************
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task print_verdict;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task wait_tog;
    logic p;
    int   i;
    p = toggle_pulse_out;
    for (i = 0; i < 20000 && toggle_pulse_out === p; i++) @(negedge clk);
    if (toggle_pulse_out === p)
    begin
      num_errors++;
      print_verdict;
    end
  endtask : wait_tog
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {arst_n, low_speed_osc, high_speed_osc, nr_clk_tick, count_source_sel} = '0;
    {event_edge_sel, glitch_filter_en, ch0_run, ch1_run, ch0_reload_trigger} = '0;
    {ch1_reload_trigger, ch0_osc_select, ch1_osc_select, ch0_div_lo, ch0_div_hi} = '0;
    {ch0_lo_read, ch0_hi_read, ch1_lo_read, ch1_hi_read, ch0_irq_mask, ch1_irq_mask} = '0;
    {ch0_irq_clear, ch1_irq_clear, toggle_pulse_out_chan_sel, ch1_div_sel} = '0;
    {num_errors, samples_checked, ecnt} = '0;
    {ch0_reload_value, ch1_reload_value} = {8'h02, 8'h02};
    toggle_pulse_out_enable = 1'b1;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    foreach (rows[r])
    begin
      {ch0_osc_select, ch1_osc_select} = {2{rows[r].osc}};
      {ch0_div_hi, ch0_div_lo} = rows[r].dv;
      ch1_div_sel = rows[r].dv;
      toggle_pulse_out_chan_sel = rows[r].ch;
      @(negedge clk);
      {ch0_reload_trigger, ch1_reload_trigger, ch0_irq_clear, ch1_irq_clear} = 4'hF;
      @(negedge clk);
      {ch0_reload_trigger, ch1_reload_trigger, ch0_irq_clear, ch1_irq_clear} = 4'h0;
      chk(rows[r].ch ? ch1_irq_flag : ch0_irq_flag, 16'h0000);
      {ch0_run, ch1_run} = {!rows[r].ch, rows[r].ch};
      wait_tog;
      e0 = ecnt;
      wait_tog;
      chk(16'(ecnt - e0), rows[r].ex);
      chk(rows[r].ch ? ch1_irq_flag : ch0_irq_flag, 16'h0001);
      chk(pulse_output_pin, toggle_pulse_out);
      {ch0_run, ch1_run} = 2'h0;
    end
    // borrow across nibbles while the high nibble is held
    {ch1_reload_value, ch1_div_sel} = {8'h10, 2'h0};
    pulse(ch1_reload_trigger);
    @(negedge clk);
    pulse(ch1_lo_read);
    ch1_run = 1'b1;
    repeat (40) @(negedge clk);
    chk(ch1_count_readout[7:4], 16'h0001);
    pulse(ch1_hi_read);
    @(negedge clk);
    chk(ch1_count_readout[7:4], 16'h0000);
    ch1_run = 1'b0;
    // event counting: prescaler left at /1 so timer ticks would show
    {count_source_sel, ch0_osc_select, ch0_div_lo, ch0_div_hi} = 4'h8;
    pulse(ch0_irq_clear);
    pulse(ch0_reload_trigger);
    ch0_run = 1'b1;
    foreach (evs[k])
    begin
      @(negedge clk);
      event_edge_sel = evs[k].e;
      dualrt_event_src_inst.set_level(evs[k].l, 400);
      chk(ch0_count_readout, evs[k].ex);
    end
    chk(ch0_irq_flag, 16'h0001);
    chk(irq_req, 16'h0000);
    @(negedge clk);
    ch0_irq_mask = 1'b1;
    @(negedge clk);
    chk(irq_req, 16'h0001);
    pulse(ch0_irq_clear);
    chk(ch0_irq_flag, 16'h0000);
    glitch_filter_en = 1'b1;
    dualrt_event_src_inst.set_level(1'b0, 20);
    dualrt_event_src_inst.set_level(1'b1, 400);
    chk(ch0_count_readout, 16'h0002);
    dualrt_event_src_inst.set_level(1'b0, 400);
    dualrt_event_src_inst.set_level(1'b1, 400);
    chk(ch0_count_readout, 16'h0001);
    @(negedge clk);
    toggle_pulse_out_enable = 1'b0;
    arst_n = 1'b0;
    @(negedge clk);
    chk({ch0_count_readout, ch1_count_readout}, 16'h0000);
    chk({ch0_irq_flag, ch1_irq_flag, irq_req, toggle_pulse_out, serial_clk_out}, 16'h0000);
    chk(pulse_output_pin, 16'h0001);
    arst_n = 1'b1;
    print_verdict;
  end
endmodule : dual_reload_down_timer_tb_top
